// file: logic/sdg_consts.vh
/*
 * Constants for the SDRAM command and timing guard (device side).
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef SDG_CONSTS_VH
`define SDG_CONSTS_VH

// ************************************************************
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ************************************************************
`define SDG_CMD_NOP     4'h7
`define SDG_CMD_ACT     4'h3
`define SDG_CMD_RD      4'h5
`define SDG_CMD_WR      4'h4
`define SDG_CMD_BST     4'h6
`define SDG_CMD_PRE     4'h2
`define SDG_CMD_REF     4'h1
`define SDG_CMD_MRS     4'h0

// ************************************************************
// Mode register fields
// ************************************************************
`define SDG_MR_BL_LSB   0
`define SDG_MR_BT_BIT   3
`define SDG_MR_CL_LSB   4
`define SDG_MR_BL_RST   3'h2
`define SDG_MR_CL_RST   3'h3
`define SDG_CL_SUPP     3'h3

// ************************************************************
// Address bit that requests auto precharge / all-bank precharge
// ************************************************************
`define SDG_AP_BIT      10

// ************************************************************
// Cycle counts and ns timings
// ************************************************************
`define SDG_CL_CYC      3
`define SDG_ROH_CYC     3
`define SDG_CKED_CYC    1
`define SDG_PED_CYC     1
`define SDG_WR_NS       20
`define SDG_TCK_NS      10
`define SDG_WR_CYC      ((`SDG_WR_NS + `SDG_TCK_NS - 1) / `SDG_TCK_NS)

`endif

// file: logic/sdg_bank.v
/*
 * One bank of the SDRAM device: row capture, open flag, auto
 * precharge at end of burst.
 * Assumes commands already decoded and qualified by clock enable.
 */
`timescale 1ns/1ns
`default_nettype none
`include "sdg_consts.vh"

module sdg_bank #(
  parameter ROW_W = 12
) (
  input  wire             clk_i,
  input  wire             resetn_i,
  input  wire             act_i,
  input  wire [ROW_W-1:0] row_i,
  input  wire             pre_i,
  input  wire             ap_done_i,
  output reg              open_o,
  output reg  [ROW_W-1:0] row_o
);

  // ************************************************************
  // Row state
  // ************************************************************
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      open_o <= 1'b0;
      row_o  <= {ROW_W{1'b0}};
    end else if (act_i) begin
      open_o <= 1'b1;                  // [RQ22]
      row_o  <= row_i;                 // [RQ22]
    end else if (pre_i || ap_done_i) begin
      open_o <= 1'b0;                  // [RQ23]
    end
  end

endmodule
`default_nettype wire

// file: logic/sdg_device.v
/*
 * Device-side command sequencer of a quad-bank SDR SDRAM: decodes
 * commands, tracks banks, runs bursts with interleaved column order,
 * data mask, clock suspend, self refresh and output release.
 * Assumes a controller that meets all its spacing and refresh duties;
 * no timing violation is checked here.
 */
// Functional notes
// [RQ1] Controller idles 100 us then issues two auto refresh before access.
// [RQ2] After refresh period violation, controller repeats two wake-up refreshes.
// [RQ3] Controller issues 4096 refreshes in every 64 ms.
// [RQ4] Activate to read or write at least 22.5 or 30 ns.
// [RQ5] Row open between 44/50 ns and 16K ns before precharge.
// [RQ6] Auto refresh to activate at least 60 or 80 ns.
// [RQ7] Precharge to activate same bank at least 22.5 or 30 ns.
// [RQ8] Activates to different banks at least 15 or 20 ns apart.
// [RQ9] Last write data to precharge: 2 clocks and 20 ns.
// [RQ10] Write with auto precharge: 5 clocks before next activate.
// [RQ11] Two clocks after mode register load before next command.
// [RQ12] Eight clocks after self refresh exit before activate.
// [RQ13] Column commands may follow each other every clock.
// [RQ14] First write data taken with the write command itself.
// [RQ15] Data mask acts on write data in the same cycle.
// [RQ16] Outputs go high impedance three clocks after precharge ends read.
// [RQ17] Clock enable low suspends or powers down one clock later.
// [RQ18] Clock enable high resumes one clock later.
// [RQ19] With latency three, clock period at least 7.5 or 10 ns.
// [RQ20] Only CAS latency three is supported.
// [RQ21] Burst length 1, 2 or 4, interleaved; device generates columns.
// [RQ22] Activate address picks bank and row; column command gives column.
// [RQ23] Auto precharge closes the row at burst end.
// [RQ24] Controller rounds ns minimums up to clocks, tracks banks.
// [RQ25] Controller spreads refreshes about every 15.6 us, refresh first.
`timescale 1ns/1ns
`default_nettype none
`include "sdg_consts.vh"

module sdg_device #(
  parameter ROW_W = 12,
  parameter COL_W = 10,
  parameter DQ_W  = 16,
  parameter DM_W  = 2
) (
  input  wire              clk_i,
  input  wire              resetn_i,
  input  wire              cke_i,
  input  wire              cs_n_i,
  input  wire              ras_n_i,
  input  wire              cas_n_i,
  input  wire              we_n_i,
  input  wire [1:0]        ba_i,
  input  wire [ROW_W-1:0]  addr_i,
  input  wire [DM_W-1:0]   dqm_i,
  input  wire [DQ_W-1:0]   dq_i,
  input  wire [DQ_W-1:0]   rd_data_i,
  output reg  [DQ_W-1:0]   dq_o,
  output reg               dq_oe_n_o,
  output reg               wr_en_o,
  output reg  [DM_W-1:0]   wr_be_o,
  output reg  [DQ_W-1:0]   wr_data_o,
  output reg               rd_en_o,
  output reg  [1:0]        mem_bank_o,
  output reg  [ROW_W-1:0]  mem_row_o,
  output reg  [COL_W-1:0]  mem_col_o,
  output reg               suspended_o,
  output reg               self_refresh_o,
  output reg               refresh_o,
  output reg  [2:0]        burst_len_o,
  output reg               cl_bad_o,
  output reg  [3:0]        bank_open_o
);

  // ************************************************************
  // Burst states
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RD   = 3'h2;
  localparam [2:0] ST_WR   = 3'h4;
  localparam [1:0] ROH_LOAD = `SDG_ROH_CYC - 1;

  reg  [2:0]       state_r;
  reg  [2:0]       state_nxt;
  reg              cke_d_r;
  reg  [2:0]       mr_bl_r;
  reg  [2:0]       beat_r;
  reg  [2:0]       blen_r;
  reg  [1:0]       bbank_r;
  reg  [COL_W-1:0] bcol_r;
  reg              bap_r;
  reg  [`SDG_CL_CYC-2:0] rd_pipe_r;
  reg  [1:0]       roh_r;
  reg              burst_end;
  wire [3:0]       cmd;
  wire             live;
  wire [ROW_W-1:0] bank_row [0:3];

  // Interleaved order is a plain XOR of beat into low column bits
  function [COL_W-1:0] ilv_col;
    input [COL_W-1:0] base;
    input [2:0]       beat;
    begin
      ilv_col = {base[COL_W-1:2], base[1:0] ^ beat[1:0]};   // [RQ21]
    end
  endfunction

  function [2:0] bl_beats;
    input [2:0] code;
    begin
      case (code)
        3'h0:    bl_beats = 3'h1;
        3'h1:    bl_beats = 3'h2;
        default: bl_beats = 3'h4;   // [RQ21]
      endcase
    end
  endfunction

  // ************************************************************
  // Command decode; clock enable registered one cycle
  // ************************************************************
  assign cmd  = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  assign live = cke_d_r && !self_refresh_o;   // [RQ17] [RQ18]

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      cke_d_r        <= 1'b1;
      suspended_o    <= 1'b0;
      self_refresh_o <= 1'b0;
      refresh_o      <= 1'b0;
      mr_bl_r        <= `SDG_MR_BL_RST;
      burst_len_o    <= 3'h4;
      cl_bad_o       <= 1'b0;
    end else begin
      cke_d_r     <= cke_i;
      suspended_o <= !cke_i;                        // [RQ17] [RQ18]
      refresh_o   <= live && cke_i && cmd == `SDG_CMD_REF;
      if (live && !cke_i && cmd == `SDG_CMD_REF && state_r == ST_IDLE)
        self_refresh_o <= 1'b1;
      else if (self_refresh_o && cke_i)
        self_refresh_o <= 1'b0;                     // [RQ18]
      if (live && cmd == `SDG_CMD_MRS) begin
        mr_bl_r     <= addr_i[`SDG_MR_BL_LSB +: 3];
        burst_len_o <= bl_beats(addr_i[`SDG_MR_BL_LSB +: 3]);
        // Any latency but three or sequential order is flagged
        cl_bad_o    <= addr_i[`SDG_MR_CL_LSB +: 3] != `SDG_CL_SUPP ||
                       !addr_i[`SDG_MR_BT_BIT];     // [RQ20] [RQ21]
      end
    end
  end

  // ************************************************************
  // Banks
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_bank
      sdg_bank #(.ROW_W(ROW_W)) u_bank (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .act_i     (live && cmd == `SDG_CMD_ACT && ba_i == g),
        .row_i     (addr_i),
        .pre_i     (live && cmd == `SDG_CMD_PRE &&
                    (addr_i[`SDG_AP_BIT] || ba_i == g)),
        .ap_done_i (burst_end && bap_r && bbank_r == g),
        .open_o    (bank_open_o[g]),
        .row_o     (bank_row[g])
      );
    end
  endgenerate

  // ************************************************************
  // Burst sequencer
  // ************************************************************
  always @* begin
    state_nxt = state_r;
    burst_end = 1'b0;
    case (state_r)
      ST_IDLE: state_nxt = ST_IDLE;
      ST_RD,
      ST_WR: begin
        if (live && beat_r + 3'h1 >= blen_r) begin
          burst_end = 1'b1;                         // [RQ23]
          state_nxt = ST_IDLE;
        end
        if (live && (cmd == `SDG_CMD_BST || cmd == `SDG_CMD_PRE))
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // A new column command cuts the running burst short
    if (live && cmd == `SDG_CMD_RD)
      state_nxt = ST_RD;                            // [RQ13]
    if (live && cmd == `SDG_CMD_WR)
      state_nxt = ST_WR;                            // [RQ13]
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r   <= ST_IDLE;
      beat_r    <= 3'h0;
      blen_r    <= 3'h1;
      bbank_r   <= 2'h0;
      bcol_r    <= {COL_W{1'b0}};
      bap_r     <= 1'b0;
      wr_en_o   <= 1'b0;
      wr_be_o   <= {DM_W{1'b0}};
      wr_data_o <= {DQ_W{1'b0}};
      rd_en_o   <= 1'b0;
      mem_bank_o <= 2'h0;
      mem_row_o <= {ROW_W{1'b0}};
      mem_col_o <= {COL_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      wr_en_o <= 1'b0;
      rd_en_o <= 1'b0;
      if (live && (cmd == `SDG_CMD_RD || cmd == `SDG_CMD_WR)) begin
        bbank_r    <= ba_i;                         // [RQ22]
        bcol_r     <= addr_i[COL_W-1:0];
        bap_r      <= addr_i[`SDG_AP_BIT];
        blen_r     <= bl_beats(mr_bl_r);
        beat_r     <= 3'h1;
        mem_bank_o <= ba_i;
        mem_row_o  <= bank_row[ba_i];
        mem_col_o  <= addr_i[COL_W-1:0];
        rd_en_o    <= cmd == `SDG_CMD_RD;
        wr_en_o    <= cmd == `SDG_CMD_WR;           // [RQ14]
        wr_data_o  <= dq_i;                         // [RQ14]
        wr_be_o    <= ~dqm_i;                       // [RQ15]
      end else if (live && (state_r == ST_RD || state_r == ST_WR) &&
                   beat_r < blen_r &&
                   cmd != `SDG_CMD_BST && cmd != `SDG_CMD_PRE) begin
        beat_r    <= beat_r + 3'h1;
        mem_col_o <= ilv_col(bcol_r, beat_r);       // [RQ21]
        rd_en_o   <= state_r == ST_RD;
        wr_en_o   <= state_r == ST_WR;
        wr_data_o <= dq_i;
        wr_be_o   <= ~dqm_i;                        // [RQ15]
      end
    end
  end

  // ************************************************************
  // Read data pipe and output release
  // ************************************************************
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_pipe_r <= {(`SDG_CL_CYC-1){1'b0}};
      roh_r     <= 2'h0;
      dq_o      <= {DQ_W{1'b0}};
      dq_oe_n_o <= 1'b1;
    end else begin
      // Stage one already holds the memory read strobe delay
      rd_pipe_r <= {rd_pipe_r[`SDG_CL_CYC-3:0], rd_en_o};    // [RQ20]
      if (live && cmd == `SDG_CMD_PRE && state_r == ST_RD)
        roh_r <= ROH_LOAD;                                   // [RQ16]
      else if (roh_r != 2'h0)
        roh_r <= roh_r - 2'h1;
      dq_o <= rd_data_i;
      if (roh_r == 2'h1)
        dq_oe_n_o <= 1'b1;                                   // [RQ16]
      else if (rd_pipe_r[`SDG_CL_CYC-2] && roh_r == 2'h0)
        dq_oe_n_o <= 1'b0;
      else if (!rd_pipe_r[`SDG_CL_CYC-2])
        dq_oe_n_o <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: tb/sdg_device_checker.sv
/* Port assertions for the SDRAM device side.
   Assumes a bind onto sdg_device from the bench top. */
`timescale 1ns/1ns
`default_nettype none
`include "sdg_consts.vh"
module sdg_device_checker (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        cke_i,
  input wire logic        cs_n_i,
  input wire logic        ras_n_i,
  input wire logic        cas_n_i,
  input wire logic        we_n_i,
  input wire logic [1:0]  ba_i,
  input wire logic [11:0] addr_i,
  input wire logic [1:0]  dqm_i,
  input wire logic [15:0] dq_i,
  input wire logic [15:0] wr_data_o,
  input wire logic [1:0]  wr_be_o,
  input wire logic        wr_en_o,
  input wire logic        rd_en_o,
  input wire logic        dq_oe_n_o,
  input wire logic        suspended_o,
  input wire logic        self_refresh_o,
  input wire logic [3:0]  bank_open_o
);
  logic       cke_q;
  wire  [3:0] cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire        tk = cke_q && !self_refresh_o;
  wire        wr = tk && cmd == `SDG_CMD_WR;
  wire        rd = tk && cmd == `SDG_CMD_RD;
  wire        pr = tk && cmd == `SDG_CMD_PRE;
  // Commands count only when last cycle's clock enable was high
  always @(posedge clk_i) cke_q <= resetn_i ? cke_i : 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ****************
  // Properties
  // ****************
  property p_wr_data; wr |=> wr_en_o && wr_data_o == $past(dq_i); endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data lost");
  property p_wr_mask; wr |=> wr_be_o == ~$past(dqm_i); endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("write mask wrong");
  property p_wr_b2b; wr ##1 wr |=> wr_en_o && wr_data_o == $past(dq_i); endproperty
  a_wr_b2b: assert property (p_wr_b2b) else $error("second write lost");
  property p_rd; rd |=> rd_en_o; endproperty
  a_rd: assert property (p_rd) else $error("read strobe missing");
  property p_sus_in; !cke_i |=> suspended_o; endproperty
  a_sus_in: assert property (p_sus_in) else $error("no suspend");
  property p_sus_out; $rose(cke_i) |=> !suspended_o; endproperty
  a_sus_out: assert property (p_sus_out) else $error("no resume");
  property p_hiz; pr && !dq_oe_n_o |-> ##3 dq_oe_n_o; endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not released");
  property p_act; tk && cmd == `SDG_CMD_ACT |=> bank_open_o[$past(ba_i)]; endproperty
  a_act: assert property (p_act) else $error("bank not opened");
  property p_pre; pr && !addr_i[10] |=> !bank_open_o[$past(ba_i)]; endproperty
  a_pre: assert property (p_pre) else $error("bank not closed");
  c_wr: cover property (wr ##1 wr);
  c_hiz: cover property (pr && !dq_oe_n_o);
  c_sus: cover property ($fell(cke_i));
endmodule
`default_nettype wire

// file: tb/sdg_ctl_model.sv
/* Controller model driving SDRAM command and data pins.
   Assumes one bench process calls its tasks. */
`timescale 1ns/1ns
`default_nettype none
`include "sdg_consts.vh"
module sdg_ctl_model (
  input  wire logic        clk_i,
  output var  logic        cke_o,
  output var  logic [3:0]  cmd_o,
  output var  logic [1:0]  ba_o,
  output var  logic [11:0] addr_o,
  output var  logic [1:0]  dqm_o,
  output var  logic [15:0] dq_o
);
  localparam int IDLE_CYC = 10000;
  initial {cke_o, cmd_o, ba_o, addr_o, dqm_o, dq_o} = {1'b1, `SDG_CMD_NOP, 32'h0};
  task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] b,
                       input logic [11:0] a, input logic [1:0] m, input logic [15:0] d);
    @(posedge clk_i);
    #1 {cke_o, cmd_o, ba_o, addr_o, dqm_o, dq_o} = {k, c, b, a, m, d};
  endtask
  // Idle data toggles so stale data never passes for fresh
  task automatic nops(input int n);
    repeat (n) issue(1'b1, `SDG_CMD_NOP, 2'h0, 12'h0, 2'h0, ~dq_o);
  endtask
  // Run after wake-up is far shorter than one refresh interval
  task automatic init;
    nops(IDLE_CYC);
    repeat (2) begin
      issue(1'b1, `SDG_CMD_REF, 2'h0, 12'h0, 2'h0, ~dq_o);
      nops(8);
    end
  endtask
  task automatic mode(input logic [2:0] bl, input logic [2:0] cl);
    issue(1'b1, `SDG_CMD_MRS, 2'h0, {5'h0, cl, 1'b1, bl}, 2'h0, ~dq_o);
    nops(2);
  endtask
endmodule
`default_nettype wire

// file: tb/sdg_device_tb.sv
/* Bench: reset, init, mode codes, writes, read cut by precharge,
   auto precharge, suspend, self refresh.
   Assumes the controller model and the checker. */
`timescale 1ns/1ns
`default_nettype none
`include "sdg_consts.vh"
module sdg_device_tb;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [15:0] rdd = 16'h0;
  logic [15:0] rdd_q = 16'h0;
  logic        live_q = 1'b0;
  logic        cke, oe_n, wr_en, rd_en, susp, selfr, refr, clb;
  logic [3:0]  cmd, bopen;
  logic [1:0]  ba, dqm, be, mbank, b;
  logic [11:0] addr, mrow;
  logic [15:0] dq, dqo, wdat;
  logic [9:0]  mcol;
  logic [2:0]  bl;
  logic [27:0] wq[$];
  logic [9:0]  rq[$];
  logic [9:0]  c[3];
  logic [15:0] d[3];
  logic [1:0]  m[3];
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          nref = 0;
  always #5 clk_i = ~clk_i;
  sdg_ctl_model u_ctl (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .addr_o(addr),
    .dqm_o(dqm), .dq_o(dq));
  sdg_device u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cke_i(cke), .cs_n_i(cmd[3]),
    .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr),
    .dqm_i(dqm), .dq_i(dq), .rd_data_i(rdd), .dq_o(dqo), .dq_oe_n_o(oe_n), .wr_en_o(wr_en),
    .wr_be_o(be), .wr_data_o(wdat), .rd_en_o(rd_en), .mem_bank_o(mbank), .mem_row_o(mrow),
    .mem_col_o(mcol), .suspended_o(susp), .self_refresh_o(selfr), .refresh_o(refr),
    .burst_len_o(bl), .cl_bad_o(clb), .bank_open_o(bopen));
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    #1 rdd = $urandom;
    cyc++;
    if (cyc > 11000) begin
      errors++;
      tally_and_finish;
    end
  end
  // Empty queue yields X, so an unexpected beat always mismatches
  always @(posedge clk_i) begin
    #2;
    if (wr_en === 1'b1) chk({mcol, be, wdat}, wq.size() ? wq.pop_front() : 28'hX);
    if (rd_en === 1'b1) chk(mcol, rq.size() ? rq.pop_front() : 10'hX);
    if ((wr_en | rd_en) === 1'b1) chk({mbank, mrow}, {b, 12'h5A5});
    // Read data out is the array word of the previous edge
    if (live_q) chk(dqo, rdd_q);
    live_q = resetn_i;
    rdd_q = rdd;
    if (refr === 1'b1) nref++;
  end
  initial begin
    void'($urandom(89471));
    repeat (6) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    chk({oe_n, bl, bopen, clb}, {1'b1, 3'h4, 4'h0, 1'b0});
    u_ctl.init();
    chk(nref, 2);
    for (int k = 0; k < 3; k++) begin
      u_ctl.mode(k[2:0], 3'h3);
      chk(bl, 3'h1 << k);
    end
    u_ctl.mode(3'h1, 3'h2);
    chk(clb, 1'b1);
    u_ctl.mode(3'h1, 3'h3);
    $display("test init and mode done");
    b = $urandom;
    u_ctl.issue(1'b1, `SDG_CMD_ACT, b, 12'h5A5, 2'h0, ~dq);
    u_ctl.nops(3);
    chk(bopen, 4'h1 << b);
    repeat (4) begin
      for (int j = 0; j < 3; j++) begin
        c[j] = $urandom;
        d[j] = $urandom;
        m[j] = $urandom;
      end
      wq.push_back({c[0], ~m[0], d[0]});
      wq.push_back({c[1], ~m[1], d[1]});
      wq.push_back({c[1] ^ 10'h1, ~m[2], d[2]});
      u_ctl.issue(1'b1, `SDG_CMD_WR, b, {2'h0, c[0]}, m[0], d[0]);
      u_ctl.issue(1'b1, `SDG_CMD_WR, b, {2'h0, c[1]}, m[1], d[1]);
      u_ctl.issue(1'b1, `SDG_CMD_NOP, 2'h0, 12'h0, m[2], d[2]);
      u_ctl.nops(2);
    end
    $display("test writes done");
    u_ctl.mode(3'h2, 3'h3);
    rq.push_back(c[0]);
    for (int j = 0; j < 3; j++) rq.push_back(c[1] ^ j[9:0]);
    u_ctl.issue(1'b1, `SDG_CMD_RD, b, {2'h0, c[0]}, 2'h0, ~dq);
    u_ctl.issue(1'b1, `SDG_CMD_RD, b, {2'h0, c[1]}, 2'h0, ~dq);
    u_ctl.nops(2);
    // Precharge cuts the final beat while read data still streams out
    u_ctl.issue(1'b1, `SDG_CMD_PRE, b, 12'h0, 2'h0, ~dq);
    u_ctl.nops(4);
    chk({oe_n, bopen}, {1'b1, 4'h0});
    $display("test read done");
    u_ctl.issue(1'b1, `SDG_CMD_ACT, b, 12'h5A5, 2'h0, ~dq);
    u_ctl.nops(3);
    for (int j = 0; j < 4; j++) wq.push_back({c[0] ^ j[9:0], ~m[j % 3], d[j % 3]});
    u_ctl.issue(1'b1, `SDG_CMD_WR, b, {2'h1, c[0]}, m[0], d[0]);
    for (int j = 1; j < 4; j++) u_ctl.issue(1'b1, `SDG_CMD_NOP, 2'h0, 12'h0, m[j % 3], d[j % 3]);
    chk(bopen, 4'h1 << b);
    u_ctl.nops(5);
    chk(bopen, 4'h0);
    $display("test auto precharge done");
    u_ctl.issue(1'b0, `SDG_CMD_NOP, 2'h0, 12'h0, 2'h0, ~dq);
    repeat (2) u_ctl.issue(1'b0, `SDG_CMD_WR, b, 12'h0, 2'h0, ~dq);
    chk(susp, 1'b1);
    u_ctl.nops(3);
    chk({susp, wq.size() + rq.size()}, 28'h0);
    $display("test suspend done");
    u_ctl.issue(1'b0, `SDG_CMD_REF, 2'h0, 12'h0, 2'h0, ~dq);
    u_ctl.issue(1'b0, `SDG_CMD_NOP, 2'h0, 12'h0, 2'h0, ~dq);
    chk({selfr, refr}, {1'b1, 1'b0});
    u_ctl.nops(8);
    chk({selfr, susp}, 2'h0);
    $display("test self refresh done");
    tally_and_finish;
  end
endmodule
bind sdg_device sdg_device_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .cke_i(cke_i),
  .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i),
  .addr_i(addr_i), .dqm_i(dqm_i), .dq_i(dq_i), .wr_data_o(wr_data_o), .wr_be_o(wr_be_o),
  .wr_en_o(wr_en_o), .rd_en_o(rd_en_o), .dq_oe_n_o(dq_oe_n_o), .suspended_o(suspended_o),
  .self_refresh_o(self_refresh_o), .bank_open_o(bank_open_o));
`default_nettype wire
